/* File: pkg/pssf_map.svh */
// Register indices, field positions, reset values and timing figures of the drain-fault supervisor.
`ifndef PSSF_MAP_SVH
`define PSSF_MAP_SVH
`define PSSF_IDX_LIVE      8'h03
`define PSSF_IDX_LATCHED   8'h04
`define PSSF_IDX_CTRL_A    8'h0A
`define PSSF_IDX_LIMIT_CFG 8'h0D
`define PSSF_IDX_TIMER_CFG 8'h0E
`define PSSF_IDX_IRQ_STAT  8'h10
`define PSSF_IDX_IRQ_MASK  8'h11
`define PSSF_IDX_ADC_CODE  8'h12
`define PSSF_IDX_ADC_UV    8'h13
`define PSSF_BIT_DRAIN     0
`define PSSF_BIT_LATCH_EV  1
`define PSSF_RST_BYTE      8'h00
`define PSSF_CLK_KHZ       50000
`define PSSF_MIN_DELAY_MS  256
`define PSSF_ADC_FS_UV     32768
`define PSSF_ADC_BITS      12
`define PSSF_RESP_OKAY     2'b00
`define PSSF_RESP_SLVERR   2'b10
`endif

/* File: pkg/pssf_pkg.sv */
// Types shared by the drain-fault supervisor.
package pssf_pkg;
    typedef struct packed {
        logic [4:0] spare;
        logic       thermal_timer_sel;
        logic       post_start_foldback_off;
        logic       drain_fault_shutoff_en;
    } pssf_ctrl_t;
    typedef struct packed {
        logic [5:0] spare;
        logic [1:0] foldback_ratio_sel;
    } pssf_limit_t;
    typedef struct packed {
        logic [3:0] spare;
        logic [1:0] drain_threshold_sel;
        logic [1:0] drain_fault_delay_sel;
    } pssf_tcfg_t;
    typedef struct packed {
        logic        gate_enable;
        logic        tmr_pullup_en;
        logic        tmr_pulldown_en;
        logic [1:0]  drain_threshold_sel;
        logic [1:0]  foldback_ratio_sel;
        logic        post_start_foldback_off;
    } pssf_drive_t;
    typedef struct packed {
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        aw_held;
        logic        w_held;
        logic [7:0]  aw_idx;
        logic [7:0]  w_byte;
        logic        w_lane;
        logic        aw_bad;
        pssf_ctrl_t  ctrl;
        pssf_limit_t limit;
        pssf_tcfg_t  tcfg;
        logic        live;
        logic        latched;
        logic        kill;
        logic        expired;
        logic [31:0] count;
        logic [1:0]  irq_stat;
        logic [1:0]  irq_mask;
        logic        irq;
        logic [15:0] adc_code;
        pssf_drive_t drive;
    } pssf_state_t;
endpackage

/* File: verilog/pssf_top.sv */
// Drain-fault supervisor of the pass transistor with its AXI4-Lite register file.
//
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "pssf_map.svh"

// Overview of operation
// - Drain above threshold sets live flag, starts timer.
// - Timer expiry sets the latched drain-fault bit.
// - Expiry removes gate only when shutoff enabled.
// - Drain above threshold enables timer pull-up.
// - Threshold select picks one of four levels.
// - Foldback select; code 11b gives 10 percent.
// - Ramp-rate startup keeps timer pull-up off.
// - Startup holds live flag, timer acts watchdog.
// - Shortest timer delay is 256 ms.
// - Converter full scale equals 32.768 mV.
// - Foldback-off bit disables foldback after startup.
// - Thermal-timer bit disables timer pull-down current.
// - Delay select; code 01b gives 512 ms.
module pssf_top #(
    parameter int unsigned MIN_DELAY_CYC = `PSSF_MIN_DELAY_MS * `PSSF_CLK_KHZ
) (
    input  wire logic                 aclk,
    input  wire logic                 aresetn,
    input  wire logic [31:0]          s_axi_awaddr,
    input  wire logic                 s_axi_awvalid,
    output logic                      s_axi_awready,
    input  wire logic [31:0]          s_axi_wdata,
    input  wire logic [3:0]           s_axi_wstrb,
    input  wire logic                 s_axi_wvalid,
    output logic                      s_axi_wready,
    output logic [1:0]                s_axi_bresp,
    output logic                      s_axi_bvalid,
    input  wire logic                 s_axi_bready,
    input  wire logic [31:0]          s_axi_araddr,
    input  wire logic                 s_axi_arvalid,
    output logic                      s_axi_arready,
    output logic [31:0]               s_axi_rdata,
    output logic [1:0]                s_axi_rresp,
    output logic                      s_axi_rvalid,
    input  wire logic                 s_axi_rready,
    input  wire logic                 drain_sense_input,
    input  wire logic                 startup_active,
    input  wire logic                 dvdt_mode,
    input  wire logic                 current_limit_active,
    input  wire logic                 gate_on_request,
    input  wire logic [15:0]          adc_sample,
    output logic                      gate_enable,
    output logic                      overcurrent_timer_node_pullup_en,
    output logic                      overcurrent_timer_node_pulldown_en,
    output logic [1:0]                drain_threshold_sel,
    output logic [1:0]                foldback_ratio_sel,
    output logic                      post_start_foldback_off,
    output logic                      irq
);
    // ******************************************************************
    // State and helpers
    // ******************************************************************
    pssf_pkg::pssf_state_t state;
    pssf_pkg::pssf_state_t next_state;

    localparam logic [31:0] MIN_CYC = 32'(MIN_DELAY_CYC);
    localparam int unsigned STEP_UV = `PSSF_ADC_FS_UV / (1 << `PSSF_ADC_BITS);
    localparam logic [15:0] ADC_STEP_UV = 16'(STEP_UV);

    function automatic logic [7:0] idx_of(input logic [31:0] addr);
        idx_of = addr[9:2];
    endfunction

    function automatic logic mapped(input logic [31:0] addr);
        logic [7:0] i;
        i = addr[9:2];
        mapped = (addr[31:10] == 22'h00_0000) && (addr[1:0] == 2'b00)
            && (i == `PSSF_IDX_LIVE || i == `PSSF_IDX_LATCHED
            || i == `PSSF_IDX_CTRL_A || i == `PSSF_IDX_LIMIT_CFG
            || i == `PSSF_IDX_TIMER_CFG || i == `PSSF_IDX_IRQ_STAT
            || i == `PSSF_IDX_IRQ_MASK || i == `PSSF_IDX_ADC_CODE
            || i == `PSSF_IDX_ADC_UV);
    endfunction

    logic        fault_cond;
    logic [31:0] delay_cyc;
    logic        expiry;
    logic        live_rise;
    logic        do_write;
    logic        wr_latched;
    logic        wr_irq_stat;
    logic [31:0] rd_word;
    logic [15:0] adc_uv;

    // ******************************************************************
    // Next-state logic
    // ******************************************************************
    always_comb begin
        next_state = state;

        // Startup counts as a drain fault so the timer guards the ramp.
        fault_cond = drain_sense_input | startup_active;
        // Each step of the delay code doubles the delay, from the shortest delay at code 0.
        delay_cyc = MIN_CYC << state.tcfg.drain_fault_delay_sel;
        expiry = 1'b0;
        live_rise = fault_cond & ~state.live;
        next_state.live = fault_cond;
        if (fault_cond) begin
            if (!state.expired) begin
                if (state.count >= delay_cyc - 32'h0000_0001) begin
                    expiry = 1'b1;
                    next_state.expired = 1'b1;
                end else begin
                    next_state.count = state.count + 32'h0000_0001;
                end
            end
        end else begin
            next_state.count = 32'h0000_0000;
            next_state.expired = 1'b0;
        end

        // ***** Register writes *****
        do_write = state.aw_held & state.w_held & ~state.bvalid;
        wr_latched = 1'b0;
        wr_irq_stat = 1'b0;
        if (s_axi_awvalid && state.awready) begin
            next_state.aw_held = 1'b1;
            next_state.aw_idx = idx_of(s_axi_awaddr);
            next_state.aw_bad = ~mapped(s_axi_awaddr);
        end
        if (s_axi_wvalid && state.wready) begin
            next_state.w_held = 1'b1;
            next_state.w_byte = s_axi_wdata[7:0];
            next_state.w_lane = s_axi_wstrb[0];
        end
        if (do_write) begin
            next_state.aw_held = 1'b0;
            next_state.w_held = 1'b0;
            next_state.bvalid = 1'b1;
            next_state.bresp = state.aw_bad ? `PSSF_RESP_SLVERR : `PSSF_RESP_OKAY;
            if (state.w_lane && !state.aw_bad) begin
                unique case (state.aw_idx)
                    `PSSF_IDX_LATCHED: wr_latched = 1'b1;
                    `PSSF_IDX_CTRL_A: next_state.ctrl = state.w_byte;
                    `PSSF_IDX_LIMIT_CFG: next_state.limit = state.w_byte;
                    `PSSF_IDX_TIMER_CFG: next_state.tcfg = state.w_byte;
                    `PSSF_IDX_IRQ_STAT: wr_irq_stat = 1'b1;
                    `PSSF_IDX_IRQ_MASK: next_state.irq_mask = state.w_byte[1:0];
                    default: ;
                endcase
            end
        end
        if (state.bvalid && s_axi_bready) begin
            next_state.bvalid = 1'b0;
        end
        next_state.awready = ~next_state.aw_held & ~next_state.bvalid;
        next_state.wready = ~next_state.w_held & ~next_state.bvalid;

        // ***** Latched fault and gate kill *****
        // Software may only clear the bit by writing a zero; a new expiry wins.
        if (wr_latched && !state.w_byte[`PSSF_BIT_DRAIN]) begin
            next_state.latched = 1'b0;
            next_state.kill = 1'b0;
        end
        if (expiry) begin
            next_state.latched = 1'b1;
            if (state.ctrl.drain_fault_shutoff_en) begin
                next_state.kill = 1'b1;
            end
        end

        // ***** Interrupt status, write one to clear, set wins *****
        if (wr_irq_stat) begin
            next_state.irq_stat = state.irq_stat & ~state.w_byte[1:0];
        end
        if (live_rise) begin
            next_state.irq_stat[`PSSF_BIT_DRAIN] = 1'b1;
        end
        if (expiry) begin
            next_state.irq_stat[`PSSF_BIT_LATCH_EV] = 1'b1;
        end
        next_state.irq = |(next_state.irq_stat & next_state.irq_mask);

        // ***** Converter readout *****
        next_state.adc_code = adc_sample;
        // One code step is full scale over 4096, read back in microvolts.
        adc_uv = 16'(state.adc_code[11:0] * ADC_STEP_UV);

        // ***** Register reads *****
        rd_word = 32'h0000_0000;
        unique case (idx_of(s_axi_araddr))
            `PSSF_IDX_LIVE: rd_word[`PSSF_BIT_DRAIN] = state.live;
            `PSSF_IDX_LATCHED: rd_word[`PSSF_BIT_DRAIN] = state.latched;
            `PSSF_IDX_CTRL_A: rd_word[7:0] = state.ctrl;
            `PSSF_IDX_LIMIT_CFG: rd_word[7:0] = state.limit;
            `PSSF_IDX_TIMER_CFG: rd_word[7:0] = state.tcfg;
            `PSSF_IDX_IRQ_STAT: rd_word[1:0] = state.irq_stat;
            `PSSF_IDX_IRQ_MASK: rd_word[1:0] = state.irq_mask;
            `PSSF_IDX_ADC_CODE: rd_word[15:0] = state.adc_code;
            `PSSF_IDX_ADC_UV: rd_word[15:0] = adc_uv;
            default: rd_word = 32'h0000_0000;
        endcase
        if (s_axi_arvalid && state.arready) begin
            next_state.rvalid = 1'b1;
            if (mapped(s_axi_araddr)) begin
                next_state.rdata = rd_word;
                next_state.rresp = `PSSF_RESP_OKAY;
            end else begin
                next_state.rdata = 32'h0000_0000;
                next_state.rresp = `PSSF_RESP_SLVERR;
            end
        end
        if (state.rvalid && s_axi_rready) begin
            next_state.rvalid = 1'b0;
        end
        next_state.arready = ~next_state.rvalid;

        // ***** Analog and gate drive *****
        // Kill overrides any turn-on request until the fault is cleared.
        next_state.drive.gate_enable = gate_on_request & ~next_state.kill;
        // A ramp-rate start must not integrate heat on the timer node.
        next_state.drive.tmr_pullup_en = (current_limit_active | drain_sense_input)
            & ~(dvdt_mode & startup_active);
        next_state.drive.tmr_pulldown_en = ~next_state.ctrl.thermal_timer_sel;
        next_state.drive.drain_threshold_sel = next_state.tcfg.drain_threshold_sel;
        next_state.drive.foldback_ratio_sel = next_state.limit.foldback_ratio_sel;
        // Startup foldback stays active whatever this bit says.
        next_state.drive.post_start_foldback_off =
            next_state.ctrl.post_start_foldback_off & ~startup_active;
    end

    // ******************************************************************
    // State register
    // ******************************************************************
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state <= '0;
            state.drive.tmr_pulldown_en <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    // ******************************************************************
    // Outputs
    // ******************************************************************
    assign s_axi_awready = state.awready;
    assign s_axi_wready = state.wready;
    assign s_axi_bvalid = state.bvalid;
    assign s_axi_bresp = state.bresp;
    assign s_axi_arready = state.arready;
    assign s_axi_rvalid = state.rvalid;
    assign s_axi_rresp = state.rresp;
    assign s_axi_rdata = state.rdata;
    assign gate_enable = state.drive.gate_enable;
    assign overcurrent_timer_node_pullup_en = state.drive.tmr_pullup_en;
    assign overcurrent_timer_node_pulldown_en = state.drive.tmr_pulldown_en;
    assign drain_threshold_sel = state.drive.drain_threshold_sel;
    assign foldback_ratio_sel = state.drive.foldback_ratio_sel;
    assign post_start_foldback_off = state.drive.post_start_foldback_off;
    assign irq = state.irq;
endmodule
`default_nettype wire

/* File: verif/pssf_properties.sv */
// Concurrent checks on the ports of the drain-fault supervisor.
`timescale 1ns/1ns
`default_nettype none
module pssf_properties (
    input wire logic        aclk,
    input wire logic        aresetn,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_wvalid,
    input wire logic        drain_sense_input,
    input wire logic        startup_active,
    input wire logic        dvdt_mode,
    input wire logic        gate_on_request,
    input wire logic        gate_enable,
    input wire logic        overcurrent_timer_node_pullup_en,
    input wire logic [1:0]  drain_threshold_sel,
    input wire logic        post_start_foldback_off
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    drain_pullup_a: assert property (drain_sense_input && !(dvdt_mode && startup_active)
        |=> overcurrent_timer_node_pullup_en) else $error("pull-up missing with drain high");
    ramp_pullup_a: assert property (dvdt_mode && startup_active
        |=> !overcurrent_timer_node_pullup_en) else $error("pull-up on in ramp startup");
    gate_cause_a: assert property (gate_enable |-> $past(gate_on_request))
        else $error("gate on without request");
    fold_start_a: assert property (post_start_foldback_off |-> !$past(startup_active))
        else $error("foldback off during startup");
    thresh_hold_a: assert property (!$past(s_axi_wvalid) && !$past(s_axi_wvalid, 2)
        && !$past(s_axi_wvalid, 3) |-> $stable(drain_threshold_sel)) else $error("threshold moved unwritten");
    resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
endmodule
bind pssf_top pssf_properties u_pssf_properties (.*);
`default_nettype wire

/* File: verif/pssf_partner.sv */
// Drain comparator model facing the supervisor's threshold select.
`timescale 1ns/1ns
`default_nettype none
module pssf_partner (
    input  wire logic [1:0] drain_threshold_sel,
    input  wire logic [8:0] drain_mv,
    output logic            drain_sense_input
);
    logic [8:0] trip_mv;
    always_comb begin
        case (drain_threshold_sel)
            2'h0: trip_mv = 9'h048;
            2'h1: trip_mv = 9'h066;
            2'h2: trip_mv = 9'h08f;
            default: trip_mv = 9'h0cb;
        endcase
        drain_sense_input = drain_mv > trip_mv;
    end
endmodule
`default_nettype wire

/* File: verif/pssf_top_test.sv */
// Self-checking bench for the drain-fault supervisor.
`timescale 1ns/1ns
`default_nettype none
`include "pssf_map.svh"
module pssf_top_test;
    typedef struct packed {logic [31:0] a; logic [31:0] d; logic [31:0] q; logic [1:0] r;} pssf_row_t;
    logic        aclk = 1'h0, aresetn = 1'h0, irq, gate_enable, drain_sense_input;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata, rd;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
    logic        s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
    logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid, post_start_foldback_off;
    logic [1:0]  s_axi_bresp, s_axi_rresp, drain_threshold_sel, foldback_ratio_sel, rsp;
    logic        startup_active = 1'h0, dvdt_mode = 1'h0, current_limit_active = 1'h0, gate_on_request = 1'h1;
    logic        overcurrent_timer_node_pullup_en, overcurrent_timer_node_pulldown_en;
    logic [15:0] adc_sample = 16'h0fff;
    logic [8:0]  drain_mv = 9'h000;
    int          n_errors = 0, samples_checked = 0, lag = 0;
    pssf_row_t   rows [6] = '{
        '{32'h0000_0028, 32'h1234_5601, 32'h0000_0001, `PSSF_RESP_OKAY},
        '{32'h0000_0034, 32'h0000_0003, 32'h0000_0003, `PSSF_RESP_OKAY},
        '{32'h0000_0038, 32'h0000_0009, 32'h0000_0009, `PSSF_RESP_OKAY},
        '{32'h0000_0044, 32'h0000_0003, 32'h0000_0003, `PSSF_RESP_OKAY},
        '{32'h0000_0080, 32'h0000_00ff, 32'h0000_0000, `PSSF_RESP_SLVERR},
        '{32'h0000_0029, 32'h0000_00ff, 32'h0000_0000, `PSSF_RESP_SLVERR}};
    // Sixteen cycles stand in for the shortest delay so a fault episode stays short.
    pssf_top #(.MIN_DELAY_CYC(16)) u_pssf_top (.*);
    pssf_partner u_pssf_partner (
        .drain_threshold_sel (drain_threshold_sel),
        .drain_mv            (drain_mv),
        .drain_sense_input   (drain_sense_input));
    always #10 aclk = ~aclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic ap, dp;
        @(posedge aclk);
        ap = 1'h1;
        dp = 1'h1;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= (lag == 0);
        while (ap || dp) begin
            @(posedge aclk);
            if (s_axi_awready) ap = 1'h0;
            if (s_axi_wready) dp = 1'h0;
            s_axi_awvalid <= ap;
            s_axi_wvalid <= dp;
        end
        // A late ready lets the response be seen waiting for the master.
        repeat (lag) @(posedge aclk);
        s_axi_bready <= 1'h1;
        do @(posedge aclk); while (!s_axi_bvalid);
        rsp = s_axi_bresp;
        s_axi_bready <= 1'h0;
    endtask
    task automatic rchk(input logic [31:0] a, input logic [31:0] exp);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= (lag == 0);
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        repeat (lag) @(posedge aclk);
        s_axi_rready <= 1'h1;
        do @(posedge aclk); while (!s_axi_rvalid);
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'h0;
        chk(rd, exp);
    endtask
    task automatic end_of_test();
        if (n_errors == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // The whole sequence needs well under a thousand cycles.
    initial begin
        #200_000;
        n_errors++;
        end_of_test();
    end
    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        chk(overcurrent_timer_node_pulldown_en, 1'h1);
        rchk(32'h0000_0028, 32'h0000_0000);
        foreach (rows[i]) begin
            wr(rows[i].a, rows[i].d);
            chk(rsp, rows[i].r);
            rchk(rows[i].a, rows[i].q);
            chk(rsp, rows[i].r);
        end
        chk(drain_threshold_sel, 2'h2);
        chk(foldback_ratio_sel, 2'h3);
        drain_mv <= 9'h08c;
        rchk(32'h0000_000c, 32'h0000_0000);
        drain_mv <= 9'h096;
        repeat (3) @(posedge aclk);
        chk(overcurrent_timer_node_pullup_en, 1'h1);
        rchk(32'h0000_000c, 32'h0000_0001);
        drain_mv <= 9'h000;
        rchk(32'h0000_000c, 32'h0000_0000);
        rchk(32'h0000_0010, 32'h0000_0000);
        drain_mv <= 9'h096;
        repeat (28) @(posedge aclk);
        chk(gate_enable, 1'h1);
        repeat (10) @(posedge aclk);
        chk(gate_enable, 1'h0);
        chk(irq, 1'h1);
        drain_mv <= 9'h000;
        rchk(32'h0000_0010, 32'h0000_0001);
        rchk(32'h0000_0040, 32'h0000_0003);
        wr(32'h0000_0044, 32'h0000_0000);
        repeat (2) @(posedge aclk);
        chk(irq, 1'h0);
        wr(32'h0000_0040, 32'h0000_0003);
        wr(32'h0000_0044, 32'h0000_0003);
        wr(32'h0000_0010, 32'h0000_0000);
        rchk(32'h0000_0010, 32'h0000_0000);
        chk(irq, 1'h0);
        chk(gate_enable, 1'h1);
        wr(32'h0000_0038, 32'h0000_0008);
        wr(32'h0000_0028, 32'h0000_0003);
        repeat (2) @(posedge aclk);
        chk(post_start_foldback_off, 1'h1);
        startup_active <= 1'h1;
        dvdt_mode <= 1'h1;
        drain_mv <= 9'h096;
        repeat (3) @(posedge aclk);
        chk(overcurrent_timer_node_pullup_en, 1'h0);
        chk(post_start_foldback_off, 1'h0);
        // With the drain back low only the startup itself keeps the flag and timer going.
        drain_mv <= 9'h000;
        rchk(32'h0000_000c, 32'h0000_0001);
        repeat (16) @(posedge aclk);
        chk(gate_enable, 1'h0);
        startup_active <= 1'h0;
        dvdt_mode <= 1'h0;
        drain_mv <= 9'h000;
        lag = 3;
        wr(32'h0000_0028, 32'h0000_0007);
        repeat (2) @(posedge aclk);
        chk(overcurrent_timer_node_pulldown_en, 1'h0);
        rchk(32'h0000_004c, 32'h0000_7ff8);
        rchk(32'h0000_0048, 32'h0000_0fff);
        // A reset in mid-run must drop the latched fault and its gate kill.
        aresetn <= 1'h0;
        repeat (2) @(posedge aclk);
        chk(overcurrent_timer_node_pulldown_en, 1'h1);
        chk(irq, 1'h0);
        chk(gate_enable, 1'h0);
        aresetn <= 1'h1;
        rchk(32'h0000_0010, 32'h0000_0000);
        chk(gate_enable, 1'h1);
        end_of_test();
    end
endmodule
`default_nettype wire
